// [sim/fer_bus_model.sv]
`default_nettype none
module fer_bus_model (
  input wire logic ref_clk,
  input wire logic [7:0] rd_data,
  output logic rd_stb,
  output logic wr_stb,
  output logic [15:0] addr,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rd_stb, wr_stb, addr, wr_data} = 26'h0;
  // Released strobes go low and address and data go inverse so a stale value never looks valid
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] v,
    output logic [7:0] d);
    @(negedge ref_clk);
    {rd_stb, wr_stb, addr, wr_data} = {!w, w, a, v};
    @(negedge ref_clk);
    {rd_stb, wr_stb, addr, wr_data} = {2'b00, ~a, ~v};
    d = rd_data;
  endtask : xfer
endmodule : fer_bus_model
`default_nettype wire

// [sim/fer_chk.sv]
`default_nettype none
module fer_chk #(parameter int CHANNELS = 8) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [CHANNELS-1:0] chan_status,
  input wire logic al_status_changed,
  input wire logic dl_status_changed,
  input wire logic net_al_status_read,
  input wire logic net_dl_status_read,
  input wire logic net_latch_times_read,
  input wire logic latch_status_idle,
  input wire logic time_latch_zero,
  input wire logic time_latch_one,
  input wire logic net_rd_stb,
  input wire logic [15:0] net_addr,
  input wire logic [7:0] net_rd_data,
  input wire logic [15:0] frame_event_field
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic rd_lo = net_rd_stb && net_addr == 16'h0210;
  wire logic [1:0] pins = {time_latch_one, time_latch_zero};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_res_zero: assert property (frame_event_field[15:12] == 4'h0 && !frame_event_field[1])
    else $error("reserved frame bit set");
  a_bit1_zero: assert property (rd_lo |=> !net_rd_data[1]) else $error("bit 1 set");
  a_chan_mirror: assert property (rd_lo |=> net_rd_data[7:4] == $past(chan_status[3:0], 2))
    else $error("low mirror wrong");
  a_high_byte: assert property (net_rd_stb && net_addr == 16'h0211
    |=> net_rd_data == {4'h0, $past(chan_status[7:4], 2)}) else $error("high byte wrong");
  a_al_set: assert property (al_status_changed ##1 rd_lo |=> net_rd_data[3])
    else $error("status event missing");
  a_dl_set: assert property (dl_status_changed ##1 rd_lo |=> net_rd_data[2])
    else $error("link event missing");
  a_dl_clear: assert property (net_dl_status_read && !dl_status_changed ##1 rd_lo
    |=> !net_rd_data[2]) else $error("link event not cleared");
  a_al_clear: assert property (net_al_status_read && !al_status_changed ##1 rd_lo
    |=> !net_rd_data[3]) else $error("status event not cleared");
  a_latch_clear: assert property (net_latch_times_read && latch_status_idle
    && pins == $past(pins) && pins == $past(pins, 2) && pins == $past(pins, 3)
    ##1 rd_lo |=> !net_rd_data[0]) else $error("latch event not cleared");
  c_al_seen: cover property (al_status_changed ##1 rd_lo);
  c_latch_clr: cover property (net_latch_times_read && latch_status_idle ##1 rd_lo);
  c_high: cover property (net_rd_stb && net_addr == 16'h0211);
endmodule : fer_chk
bind fer_top fer_chk #(.CHANNELS(CHANNELS)) i_fer_chk (.*);
`default_nettype wire

// [sim/fer_top_tb.sv]
`default_nettype none
module fer_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, idle, lat0, lat1, lat_rd, irq, nr, nw, hr, hw;
  logic [1:0] ev_set, ev_clr;
  logic [7:0] chan, nwd, nrdd, hwd, hrdd;
  logic [15:0] flags, frame, na, ha;
  int bad_count = 0;
  int num_checks = 0;
  fer_top i_fer_top (.ref_clk(clk), .nrst(nrst), .chan_status(chan), .chan_irq_flags(flags),
    .al_status_changed(ev_set[1]), .dl_status_changed(ev_set[0]),
    .net_al_status_read(ev_clr[1]), .net_dl_status_read(ev_clr[0]),
    .net_latch_times_read(lat_rd), .latch_status_idle(idle), .time_latch_zero(lat0),
    .time_latch_one(lat1), .net_rd_stb(nr), .net_wr_stb(nw), .net_addr(na), .net_wr_data(nwd),
    .net_rd_data(nrdd), .host_rd_stb(hr), .host_wr_stb(hw), .host_addr(ha),
    .host_wr_data(hwd), .host_rd_data(hrdd), .frame_event_field(frame), .host_irq(irq));
  fer_bus_model i_net (.ref_clk(clk), .rd_data(nrdd), .rd_stb(nr), .wr_stb(nw), .addr(na),
    .wr_data(nwd));
  fer_bus_model i_host (.ref_clk(clk), .rd_data(hrdd), .rd_stb(hr), .wr_stb(hw), .addr(ha),
    .wr_data(hwd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic h, input logic w, input logic [15:0] a, input logic [7:0] v);
    logic [7:0] d;
    if (h) i_host.xfer(w, a, v, d);
    else i_net.xfer(w, a, v, d);
    if (!w) chk(d, v);
  endtask : acc
  task automatic pulse(input logic [1:0] s, input logic [1:0] c);
    {ev_set, ev_clr} = {s, c};
    @(posedge clk);
    {ev_set, ev_clr} <= 4'h0;
  endtask : pulse
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    test_done();
  end
  initial begin
    {nrst, idle, lat0, lat1, lat_rd, ev_set, ev_clr, chan, flags} = '0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 1'b0, 16'h0204 + 16'(i), 8'(32'h00ff_ff0f >> (8 * i)));
      acc(1'b0, 1'b0, 16'h0220 + 16'(i), 8'h00);
    end
    chan = 8'ha5;
    acc(1'b0, 1'b1, 16'h0211, 8'hff);
    acc(1'b1, 1'b1, 16'h0210, 8'hff);
    acc(1'b0, 1'b0, 16'h0210, 8'h50);
    acc(1'b1, 1'b0, 16'h0211, 8'h0a);
    for (int n = 0; n < 8; n++) begin
      flags = 16'h1 << (2 * n + n % 2);
      acc(1'b1, 1'b0, 16'h0221, 8'h1 << n);
      chk(irq, 1'b1);
    end
    acc(1'b1, 1'b1, 16'h0205, 8'h7f);
    acc(1'b0, 1'b1, 16'h0205, 8'hff);
    acc(1'b1, 1'b0, 16'h0205, 8'h7f);
    chk(irq, 1'b0);
    acc(1'b0, 1'b1, 16'h0200, 8'h0d);
    acc(1'b0, 1'b1, 16'h0201, 8'h0f);
    for (int k = 0; k < 2; k++) begin
      // Set and clear in one cycle: the set must win
      pulse(2'b01 << k, 2'b01 << k);
      acc(1'b0, 1'b0, 16'h0210, 8'h50 | (8'h04 << k));
      chk(frame, 16'h0a00 | (16'h4 << k));
      pulse(2'b00, 2'b01 << k);
      acc(1'b0, 1'b0, 16'h0210, 8'h50);
    end
    for (int j = 0; j < 2; j++) begin
      {lat1, lat0} = {lat1, lat0} | (2'b01 << j);
      repeat (4) @(negedge clk);
      acc(1'b0, 1'b0, 16'h0210, 8'h51);
      chk(frame, 16'h0a01);
      // Times read while a latch still shows an event: flag stays up
      lat_rd = 1'b1;
      acc(1'b0, 1'b0, 16'h0210, 8'h51);
      idle = 1'b1;
      @(posedge clk);
      {lat_rd, idle} <= 2'b00;
      acc(1'b0, 1'b0, 16'h0210, 8'h50);
    end
    // Mid-run reset with both latch pins parked high
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    chk(frame, 16'h0000);
    chk(irq, 1'b0);
    acc(1'b0, 1'b0, 16'h0200, 8'h00);
    acc(1'b1, 1'b0, 16'h0205, 8'hff);
    acc(1'b0, 1'b0, 16'h0210, 8'h50);
    chk(irq, 1'b1);
    test_done();
  end
endmodule : fer_top_tb
`default_nettype wire

// [src/fer_params.svh]
`ifndef FER_PARAMS_SVH
`define FER_PARAMS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define FER_NET_MASK_OFS 16'h0200
`define FER_HOST_MASK_OFS 16'h0204
`define FER_NET_REQ_OFS 16'h0210
`define FER_HOST_REQ_OFS 16'h0220
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define FER_NET_MASK_RST 16'h0000
`define FER_HOST_MASK_RST 32'h00ff_ff0f
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define FER_NET_LATCH_BIT 0
`define FER_NET_DL_BIT 2
`define FER_NET_AL_BIT 3
`define FER_NET_CHAN_LSB 4
`define FER_HOST_CHAN_LSB 8
`endif

// [src/fer_pkg.sv]
`default_nettype none
package fer_pkg;
  typedef logic [15:0] fer_addr_type;
  typedef logic [7:0] fer_byte_type;
  typedef logic [15:0] fer_net_word_type;
  typedef logic [31:0] fer_host_word_type;
  // Which register a byte address hits
  typedef enum logic [2:0] {
    FER_SEL_NONE = 3'b000,
    FER_SEL_NET_MASK = 3'b001,
    FER_SEL_HOST_MASK = 3'b010,
    FER_SEL_NET_REQ = 3'b011,
    FER_SEL_HOST_REQ = 3'b100
  } fer_sel_type;
endpackage : fer_pkg
`default_nettype wire

// [src/fer_top.sv]
`include "fer_params.svh"
`default_nettype none
module fer_top #(
  parameter int CHANNELS = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [CHANNELS-1:0] chan_status,
  input wire logic [2*CHANNELS-1:0] chan_irq_flags,
  input wire logic al_status_changed,
  input wire logic dl_status_changed,
  input wire logic net_al_status_read,
  input wire logic net_dl_status_read,
  input wire logic net_latch_times_read,
  input wire logic latch_status_idle,
  input wire logic time_latch_zero,
  input wire logic time_latch_one,
  input wire logic net_rd_stb,
  input wire logic net_wr_stb,
  input wire logic [15:0] net_addr,
  input wire logic [7:0] net_wr_data,
  output logic [7:0] net_rd_data,
  input wire logic host_rd_stb,
  input wire logic host_wr_stb,
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_wr_data,
  output logic [7:0] host_rd_data,
  output logic [15:0] frame_event_field,
  output logic host_irq
);
  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic fer_pkg::fer_sel_type sel_of(input fer_pkg::fer_addr_type a);
    if (a[15:1] == `FER_NET_MASK_OFS >> 1) begin
      return fer_pkg::FER_SEL_NET_MASK;
    end else if (a[15:2] == `FER_HOST_MASK_OFS >> 2) begin
      return fer_pkg::FER_SEL_HOST_MASK;
    end else if (a[15:1] == `FER_NET_REQ_OFS >> 1) begin
      return fer_pkg::FER_SEL_NET_REQ;
    end else if (a[15:2] == `FER_HOST_REQ_OFS >> 2) begin
      return fer_pkg::FER_SEL_HOST_REQ;
    end
    return fer_pkg::FER_SEL_NONE;
  endfunction : sel_of

  // Byte lane n of a 32-bit value, lowest address = LSB
  function automatic fer_pkg::fer_byte_type lane(input fer_pkg::fer_host_word_type w,
                                                 input logic [1:0] n);
    return w[8*n +: 8];
  endfunction : lane

  // Replace byte lane n of a 32-bit value, lowest address = LSB
  function automatic fer_pkg::fer_host_word_type put_lane(input fer_pkg::fer_host_word_type w,
                                                          input logic [1:0] n,
                                                          input fer_pkg::fer_byte_type b);
    fer_pkg::fer_host_word_type r;
    r = w;
    r[8*n +: 8] = b;
    return r;
  endfunction : put_lane

  // ------------------------------------------------------------
  // Latch pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] sync1_q, sync1_d;
  logic [1:0] sync2_q, sync2_d;
  logic [1:0] latch_prev_q, latch_prev_d;
  logic armed_q, armed_d;
  logic latch_edge;

  // Pipeline keeps sampling in reset, so a pin parked high gives no false edge
  always_comb begin
    sync1_d = {time_latch_one, time_latch_zero};
    sync2_d = sync1_q;
    latch_prev_d = sync2_q;
    armed_d = nrst;
    latch_edge = armed_q & (|(sync2_q ^ latch_prev_q));
  end

  always_ff @(posedge ref_clk) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
    latch_prev_q <= latch_prev_d;
    armed_q <= armed_d;
  end

  // ------------------------------------------------------------
  // Event request and mask registers
  // ------------------------------------------------------------
  logic [CHANNELS-1:0] chan_mirror_q, chan_mirror_d;
  logic [CHANNELS-1:0] chan_irq_q, chan_irq_d;
  logic al_evt_q, al_evt_d;
  logic dl_evt_q, dl_evt_d;
  logic latch_evt_q, latch_evt_d;
  fer_pkg::fer_net_word_type net_mask_q, net_mask_d;
  fer_pkg::fer_host_word_type host_mask_q, host_mask_d;
  fer_pkg::fer_net_word_type net_req;
  fer_pkg::fer_host_word_type host_req;

  always_comb begin
    // Mirrors lag their inputs by one clock
    chan_mirror_d = chan_status;
    for (int n = 0; n < CHANNELS; n++) begin
      chan_irq_d[n] = chan_irq_flags[2*n] | chan_irq_flags[2*n+1];
    end
    // Set beats clear so a change in the read cycle is not lost
    al_evt_d = al_status_changed | (al_evt_q & ~net_al_status_read);
    dl_evt_d = dl_status_changed | (dl_evt_q & ~net_dl_status_read);
    latch_evt_d = latch_edge |
                  (latch_evt_q & ~(net_latch_times_read & latch_status_idle));
    // Network mask takes network writes only
    net_mask_d = net_mask_q;
    if (net_wr_stb && sel_of(net_addr) == fer_pkg::FER_SEL_NET_MASK) begin
      net_mask_d = 16'(put_lane({16'h0000, net_mask_q}, {1'b0, net_addr[0]}, net_wr_data));
    end
    // Host mask takes host writes only
    host_mask_d = host_mask_q;
    if (host_wr_stb && sel_of(host_addr) == fer_pkg::FER_SEL_HOST_MASK) begin
      host_mask_d = put_lane(host_mask_q, host_addr[1:0], host_wr_data);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      chan_mirror_q <= '0;
      chan_irq_q <= '0;
      al_evt_q <= 1'b0;
      dl_evt_q <= 1'b0;
      latch_evt_q <= 1'b0;
      net_mask_q <= `FER_NET_MASK_RST;
      host_mask_q <= `FER_HOST_MASK_RST;
    end else begin
      chan_mirror_q <= chan_mirror_d;
      chan_irq_q <= chan_irq_d;
      al_evt_q <= al_evt_d;
      dl_evt_q <= dl_evt_d;
      latch_evt_q <= latch_evt_d;
      net_mask_q <= net_mask_d;
      host_mask_q <= host_mask_d;
    end
  end

  // Request words; writes never reach these, reserved bits are zero
  always_comb begin
    net_req = 16'h0000;
    net_req[`FER_NET_CHAN_LSB +: CHANNELS] = chan_mirror_q;
    net_req[`FER_NET_AL_BIT] = al_evt_q;
    net_req[`FER_NET_DL_BIT] = dl_evt_q;
    net_req[`FER_NET_LATCH_BIT] = latch_evt_q;
    host_req = 32'h0000_0000;
    host_req[`FER_HOST_CHAN_LSB +: CHANNELS] = chan_irq_q;
  end

  // ------------------------------------------------------------
  // Read ports and outputs
  // ------------------------------------------------------------
  logic [7:0] net_rd_q, net_rd_d;
  logic [7:0] host_rd_q, host_rd_d;
  logic [15:0] frame_q, frame_d;
  logic irq_q, irq_d;

  // Same map from both sides; reads have no side effects
  function automatic fer_pkg::fer_byte_type read_byte(input fer_pkg::fer_addr_type a,
                                                      input fer_pkg::fer_net_word_type nm,
                                                      input fer_pkg::fer_host_word_type hm,
                                                      input fer_pkg::fer_net_word_type nr,
                                                      input fer_pkg::fer_host_word_type hr);
    case (sel_of(a))
      fer_pkg::FER_SEL_NET_MASK: return lane({16'h0000, nm}, {1'b0, a[0]});
      fer_pkg::FER_SEL_HOST_MASK: return lane(hm, a[1:0]);
      fer_pkg::FER_SEL_NET_REQ: return lane({16'h0000, nr}, {1'b0, a[0]});
      fer_pkg::FER_SEL_HOST_REQ: return lane(hr, a[1:0]);
      default: return 8'h00;
    endcase
  endfunction : read_byte

  always_comb begin
    // Read byte holds until the next read strobe
    net_rd_d = net_rd_q;
    if (net_rd_stb) begin
      net_rd_d = read_byte(net_addr, net_mask_q, host_mask_q, net_req, host_req);
    end
    host_rd_d = host_rd_q;
    if (host_rd_stb) begin
      host_rd_d = read_byte(host_addr, net_mask_q, host_mask_q, net_req, host_req);
    end
    frame_d = net_req & net_mask_q;
    irq_d = |(host_req & host_mask_q);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      net_rd_q <= 8'h00;
      host_rd_q <= 8'h00;
      frame_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      net_rd_q <= net_rd_d;
      host_rd_q <= host_rd_d;
      frame_q <= frame_d;
      irq_q <= irq_d;
    end
  end

  assign net_rd_data = net_rd_q;
  assign host_rd_data = host_rd_q;
  assign frame_event_field = frame_q;
  assign host_irq = irq_q;
endmodule : fer_top
`default_nettype wire
